// ---- inc/clkregs_pkg.sv ----
// Purpose: Shared constants and types for the clock output control registers
// Assumes: Six 8-bit control bytes reached over a two-wire serial slave
// Notes:   Bit positions are within the byte named by the offset
package clkregs_pkg;

  localparam int         NUM_REGS         = 6;
  localparam logic [7:0] SLAVE_ADDR_BYTE  = 8'hD2;
  localparam int         CMD_BYTE_MODE    = 7;
  localparam logic [7:0] BLOCK_READ_COUNT = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT      = 4'h7;

  localparam logic [2:0] OFS_SRC_EN    = 3'h0;
  localparam logic [2:0] OFS_MISC_EN   = 3'h1;
  localparam logic [2:0] OFS_BUS_EN    = 3'h2;
  localparam logic [2:0] OFS_SRC_STOP  = 3'h3;
  localparam logic [2:0] OFS_FREE_STOP = 3'h4;
  localparam logic [2:0] OFS_DRIVE     = 3'h5;

  localparam logic [7:0] RST_SRC_EN    = 8'hFF;
  localparam logic [7:0] RST_MISC_EN   = 8'hF6;
  localparam logic [7:0] RST_BUS_EN    = 8'hFF;
  localparam logic [7:0] RST_SRC_STOP  = 8'h00;
  localparam logic [7:0] RST_FREE_STOP = 8'h07;
  localparam logic [7:0] RST_DRIVE     = 8'h00;

  // Byte 0
  localparam int SHARED_EN_BIT    = 7;
  localparam int SRC_EN_LSB       = 1;
  // Byte 1
  localparam int FREE0_EN_BIT     = 7;
  localparam int DOT_EN_BIT       = 6;
  localparam int USB_EN_BIT       = 5;
  localparam int REF_EN_BIT       = 4;
  localparam int CPU_EN_LSB       = 1;
  localparam int SPREAD_BIT       = 0;
  // Byte 2
  localparam int PCI_EN_LSB       = 2;
  localparam int FREE_EN_LSB      = 0;
  // Byte 3
  localparam int SRC_STOP_LSB     = 1;
  localparam int SHARED_STOP_BIT  = 7;
  // Byte 4
  localparam int DOT_PD_HIZ_BIT   = 6;
  localparam int FREE_STOP_LSB    = 3;
  // Byte 5
  localparam int SRC_STOP_HIZ_BIT = 7;
  localparam int SRC_PD_HIZ_BIT   = 3;
  localparam int CPU2_PD_HIZ_BIT  = 2;
  localparam int CPU_PD_HIZ_LSB   = 0;

  typedef enum logic [3:0] {
    SV_IDLE, SV_WAIT, SV_ADDR, SV_CMD, SV_COUNT, SV_WDATA, SV_ACK, SV_TX, SV_MACK
  } serial_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } line_ev_t;

  typedef struct packed {
    logic       shared_drive;
    logic       shared_run;
    logic [6:1] src_drive;
    logic [6:1] src_run;
    logic [1:0] cpu_drive;
    logic [1:0] cpu_run;
    logic [5:0] pci_drive;
    logic [5:0] pci_run;
    logic [2:0] free_drive;
    logic [2:0] free_run;
    logic       dot_drive;
    logic       dot_run;
    logic       usb_drive;
    logic       usb_run;
    logic       ref_drive;
    logic       ref_run;
    logic       spread_en;
  } clk_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } edge_state_t;

  typedef struct packed {
    logic stopped;
  } align_state_t;

  typedef struct packed {
    serial_state_t      st;
    serial_state_t      ret;
    logic [7:0]         sh;
    logic [3:0]         cnt;
    logic [6:0]         ptr;
    logic               blk;
    logic               hdr;
    logic               sda_oe;
    logic [5:0][7:0]    regs;
    clk_ctrl_t          ctl;
  } slave_state_t;

endpackage

// ---- rtl/line_edges.sv ----
// Purpose: Start, stop and clock edge events of the two-wire serial bus
// Assumes: Both lines already synchronous to clock_i
// Notes:   Events are one-cycle pulses, combinational from the last sample
`timescale 1ns/1ns
module line_edges (
  input  wire logic                 clock_i,
  input  wire logic                 nrst_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output clkregs_pkg::line_ev_t     ev_o
);
  import clkregs_pkg::*;

  edge_state_t s_r;
  edge_state_t s_nxt;

  always_comb begin
    s_nxt.scl = scl_i;
    s_nxt.sda = sda_i;
    if (!nrst_i) begin
      // Idle bus level, so release of reset makes no false edge
      s_nxt = '{scl: 1'b1, sda: 1'b1};
    end
  end

  always_ff @(posedge clock_i) begin
    s_r <= s_nxt;
  end

  always_comb begin
    ev_o.start    = s_r.scl & scl_i & s_r.sda & ~sda_i;
    ev_o.stop     = s_r.scl & scl_i & ~s_r.sda & sda_i;
    ev_o.scl_rise = ~s_r.scl & scl_i;
    ev_o.scl_fall = s_r.scl & ~scl_i;
    ev_o.sda      = sda_i;
  end

endmodule // line_edges

// ---- rtl/stop_align.sv ----
// Purpose: Aligns the software stop to the common low phase of the outputs
// Assumes: phase_tick_i pulses when every stoppable output sits low
// Notes:   Entry and exit both wait for a tick, so no short pulse is cut
`timescale 1ns/1ns
module stop_align (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic stop_req_i,
  input  wire logic phase_tick_i,
  output logic      stopped_o
);
  import clkregs_pkg::*;

  align_state_t s_r;
  align_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (phase_tick_i) begin
      s_nxt.stopped = stop_req_i;
    end
    if (!nrst_i) begin
      s_nxt.stopped = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    s_r <= s_nxt;
  end

  assign stopped_o = s_r.stopped;

endmodule // stop_align

// ---- rtl/clock_output_control_regs.sv ----
// Purpose: Six control bytes of a multi-output clock synthesizer, their
//          two-wire serial slave, and the per-output drive and run gating
// Assumes: Serial lines and control pins synchronous to clock_i; the
//          synthesis logic honours each drive (else Hi-Z) and run (else low)
// Notes:   Bytes at offsets 6 and above read as zero and ignore writes
// Operation
// - Byte0 bit7 enables shared CPU2/SRC7 output
// - Byte0 bits6..1 enable SRC outputs 6..1
// - Byte1 bits 7,5,4: free0, USB, reference enables
// - Byte1 bit6 enables 96 MHz display clock
// - Byte1 bits2,1 enable CPU outputs 1,0
// - Byte1 bit0 turns spread spectrum on
// - Byte2 enables bus clocks and free clocks
// - Byte3 bits7..1 make SRC outputs stoppable
// - Byte4 bits5..3 make free clocks stoppable
// - Byte4 bit6 display clock Hi-Z in power-down
// - Byte5 bit7 stopped SRC outputs Hi-Z
// - Byte5 bit3 SRC outputs Hi-Z in power-down
// - Byte5 bits2..0 CPU outputs Hi-Z in power-down
// - Stop and restart synchronously, without short pulses
// - All bytes load defaults at power-up
// - Slave address D2h; command selects byte/block
`timescale 1ns/1ns
module clock_output_control_regs (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  input  wire logic             power_down_input_i,
  input  wire logic             software_bus_clock_stop_n_i,
  input  wire logic             debug_port_clock_select_i,
  input  wire logic             stop_phase_tick_i,
  output clkregs_pkg::clk_ctrl_t ctrl_o
);
  import clkregs_pkg::*;

  slave_state_t s_r;
  slave_state_t s_nxt;
  line_ev_t     ev;
  logic         stopped;
  logic [7:0]   rbyte;
  logic [7:0]   txb;
  clk_ctrl_t    ctl_c;

  line_edges u_edges (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ev_o    (ev)
  );

  stop_align u_align (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .stop_req_i   (~software_bus_clock_stop_n_i),
    .phase_tick_i (stop_phase_tick_i),
    .stopped_o    (stopped)
  );

  // Control bytes as named views of the register image
  logic [7:0] r_src_en;
  logic [7:0] r_misc_en;
  logic [7:0] r_bus_en;
  logic [7:0] r_src_stop;
  logic [7:0] r_free_stop;
  logic [7:0] r_drive;

  assign r_src_en    = s_r.regs[OFS_SRC_EN];
  assign r_misc_en   = s_r.regs[OFS_MISC_EN];
  assign r_bus_en    = s_r.regs[OFS_BUS_EN];
  assign r_src_stop  = s_r.regs[OFS_SRC_STOP];
  assign r_free_stop = s_r.regs[OFS_FREE_STOP];
  assign r_drive     = s_r.regs[OFS_DRIVE];

  logic pd;
  assign pd = power_down_input_i;

  // Unmapped offsets read zero rather than aliasing a real byte
  assign rbyte = (s_r.ptr < 7'(NUM_REGS)) ? s_r.regs[s_r.ptr[2:0]] : 8'h00;
  assign txb   = s_r.hdr ? BLOCK_READ_COUNT : rbyte;

  // SRC outputs 6..1: enable, stop mask, stop and power-down drive modes
  logic [6:1] src_en;
  logic [6:1] src_halt;
  logic [6:1] src_run_w;
  logic [6:1] src_drive_w;

  assign src_en = r_src_en[SRC_EN_LSB +: 6];

  for (genvar i = 1; i <= 6; i++) begin : g_src
    assign src_halt[i]    = stopped & r_src_stop[SRC_STOP_LSB + i - 1];
    assign src_run_w[i]   = src_en[i] & ~pd & ~src_halt[i];
    assign src_drive_w[i] = src_en[i]
                          & ~(pd & r_drive[SRC_PD_HIZ_BIT])
                          & ~(src_halt[i] & r_drive[SRC_STOP_HIZ_BIT]);
  end

  // Shared pair acts as CPU2 when the debug select is high, else as SRC7
  logic sh_en;
  logic sh_halt;
  logic sh_pd_hiz;
  logic [2:0] free_en;
  logic [2:0] free_halt;
  logic [1:0] cpu_en;

  assign sh_en     = r_src_en[SHARED_EN_BIT];
  assign sh_halt   = ~debug_port_clock_select_i & stopped
                   & r_src_stop[SHARED_STOP_BIT];
  assign sh_pd_hiz = debug_port_clock_select_i ? r_drive[CPU2_PD_HIZ_BIT]
                                               : r_drive[SRC_PD_HIZ_BIT];
  assign free_en   = {r_bus_en[FREE_EN_LSB +: 2], r_misc_en[FREE0_EN_BIT]};
  assign free_halt = {3{stopped}} & r_free_stop[FREE_STOP_LSB +: 3];
  assign cpu_en    = r_misc_en[CPU_EN_LSB +: 2];

  always_comb begin
    ctl_c.shared_run   = sh_en & ~pd & ~sh_halt;
    ctl_c.shared_drive = sh_en & ~(pd & sh_pd_hiz)
                       & ~(sh_halt & r_drive[SRC_STOP_HIZ_BIT]);
    ctl_c.src_run      = src_run_w;
    ctl_c.src_drive    = src_drive_w;
    ctl_c.cpu_run      = cpu_en & {2{~pd}};
    ctl_c.cpu_drive    = cpu_en
                       & ~({2{pd}} & r_drive[CPU_PD_HIZ_LSB +: 2]);
    // Bus clocks always obey the stop; they are held low, never Hi-Z
    ctl_c.pci_drive    = r_bus_en[PCI_EN_LSB +: 6];
    ctl_c.pci_run      = r_bus_en[PCI_EN_LSB +: 6] & {6{~pd & ~stopped}};
    ctl_c.free_drive   = free_en;
    ctl_c.free_run     = free_en & {3{~pd}} & ~free_halt;
    ctl_c.dot_drive    = r_misc_en[DOT_EN_BIT]
                       & ~(pd & r_free_stop[DOT_PD_HIZ_BIT]);
    ctl_c.dot_run      = r_misc_en[DOT_EN_BIT] & ~pd;
    ctl_c.usb_drive    = r_misc_en[USB_EN_BIT];
    ctl_c.usb_run      = r_misc_en[USB_EN_BIT] & ~pd;
    ctl_c.ref_drive    = r_misc_en[REF_EN_BIT];
    ctl_c.ref_run      = r_misc_en[REF_EN_BIT] & ~pd;
    ctl_c.spread_en    = r_misc_en[SPREAD_BIT];
  end

  // Serial slave and register file
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ctl = ctl_c;
    if (ev.start) begin
      // A repeated start keeps the pointer and the access mode
      s_nxt.st     = SV_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (ev.stop) begin
      s_nxt.st     = SV_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        SV_ADDR, SV_CMD, SV_COUNT, SV_WDATA: begin
          if (ev.scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], ev.sda};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
          // First fall after a start precedes any data bit; cnt is zero
          if (ev.scl_fall && s_r.cnt == BITS_PER_BYTE) begin
            s_nxt.st     = SV_ACK;
            s_nxt.sda_oe = 1'b1;
            case (s_r.st)
              SV_ADDR: begin
                if (s_r.sh[7:1] == SLAVE_ADDR_BYTE[7:1]) begin
                  s_nxt.hdr = s_r.sh[0] & s_r.blk;
                  s_nxt.ret = s_r.sh[0] ? SV_TX : SV_CMD;
                end else begin
                  // Not our address: stay off the bus until the next start
                  s_nxt.st     = SV_WAIT;
                  s_nxt.sda_oe = 1'b0;
                end
              end
              SV_CMD: begin
                s_nxt.blk = ~s_r.sh[CMD_BYTE_MODE];
                s_nxt.ptr = s_r.sh[CMD_BYTE_MODE] ? s_r.sh[6:0] : 7'h00;
                s_nxt.ret = s_r.sh[CMD_BYTE_MODE] ? SV_WDATA : SV_COUNT;
              end
              SV_COUNT: begin
                // Count is taken as a formality; the stop ends the block
                s_nxt.ret = SV_WDATA;
              end
              default: begin
                if (s_r.ptr < 7'(NUM_REGS)) begin
                  s_nxt.regs[s_r.ptr[2:0]] = s_r.sh;
                end
                s_nxt.ptr = s_r.ptr + 7'h01;
                s_nxt.ret = SV_WDATA;
              end
            endcase
          end
        end
        SV_ACK: begin
          if (ev.scl_fall) begin
            s_nxt.st  = s_r.ret;
            s_nxt.cnt = 4'h0;
            if (s_r.ret == SV_TX) begin
              s_nxt.sh     = txb;
              s_nxt.sda_oe = ~txb[7];
            end else begin
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        SV_TX: begin
          if (ev.scl_fall) begin
            if (s_r.cnt == LAST_TX_BIT) begin
              s_nxt.st     = SV_MACK;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sh     = {s_r.sh[6:0], 1'b0};
              s_nxt.cnt    = s_r.cnt + 4'h1;
              s_nxt.sda_oe = ~s_r.sh[6];
            end
          end
        end
        SV_MACK: begin
          if (ev.scl_rise) begin
            if (ev.sda) begin
              // Master declined more data
              s_nxt.st = SV_WAIT;
            end else begin
              // Next byte is loaded on the coming fall, as after an ack
              s_nxt.st  = SV_ACK;
              s_nxt.ret = SV_TX;
              s_nxt.hdr = 1'b0;
              if (!s_r.hdr) begin
                s_nxt.ptr = s_r.ptr + 7'h01;
              end
            end
          end
        end
        SV_IDLE, SV_WAIT: begin
          s_nxt.sda_oe = 1'b0;
        end
        default: begin
          s_nxt.st     = SV_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    if (!nrst_i) begin
      s_nxt.st     = SV_IDLE;
      s_nxt.ret    = SV_IDLE;
      s_nxt.sh     = 8'h00;
      s_nxt.cnt    = 4'h0;
      s_nxt.ptr    = 7'h00;
      s_nxt.blk    = 1'b0;
      s_nxt.hdr    = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.ctl    = '0;
      // Defaults make serial configuration optional
      s_nxt.regs   = {RST_DRIVE, RST_FREE_STOP, RST_SRC_STOP,
                      RST_BUS_EN, RST_MISC_EN, RST_SRC_EN};
    end
  end

  always_ff @(posedge clock_i) begin
    s_r <= s_nxt;
  end

  // Open drain: the line is only ever pulled low
  assign sda_o    = 1'b0;
  assign sda_oe_o = s_r.sda_oe;
  assign ctrl_o   = s_r.ctl;

endmodule // clock_output_control_regs

// ---- dv/host_model.sv ----
// Purpose: Serial host model for the control register slave
// Assumes: Pulled-up data line that either side may pull low
// Notes:   Data moves 2 clocks into the 6-clock low phase; 4 clocks high
`timescale 1ns/1ns
module host_model (
  input  wire logic  clock_i,
  input  wire logic  dev_oe_i,
  output logic       scl_o,
  output logic       sda_o,
  output logic       rd_valid_o,
  output logic [7:0] rd_data_o
);
  logic pull_low = 1'b0;
  initial begin
    scl_o = 1'b1;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end
  // Released line floats back high
  assign sda_o = ~(pull_low | dev_oe_i);
  task automatic clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic bit_cycle(input logic b, output logic s);
    clk(2);
    pull_low <= ~b;
    clk(4);
    scl_o <= 1'b1;
    clk(2);
    @(negedge clock_i) s = sda_o;
    clk(2);
    scl_o <= 1'b0;
  endtask
  task automatic cond(input logic a, input logic b);
    clk(2);
    pull_low <= a;
    clk(4);
    scl_o <= 1'b1;
    clk(4);
    pull_low <= b;
    clk(4);
  endtask
  task automatic start();
    cond(1'b0, 1'b1);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    cond(1'b1, 1'b0);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic last);
    logic       s;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b1, s);
      d = {d[6:0], s};
    end
    bit_cycle(last, s);
    rd_data_o <= d;
    rd_valid_o <= 1'b1;
    clk(1);
    rd_valid_o <= 1'b0;
  endtask
endmodule // host_model

// ---- dv/clock_output_control_regs_checker.sv ----
// Purpose: Port properties of the clock output control registers
// Assumes: One clock domain, bound to the top module
// Notes:   Register contents are unseen; only their effects are checked
`timescale 1ns/1ns
module clock_output_control_regs_checker (
  input wire logic                   clock_i,
  input wire logic                   nrst_i,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   sda_oe_o,
  input wire logic                   power_down_input_i,
  input wire logic                   software_bus_clock_stop_n_i,
  input wire logic                   stop_phase_tick_i,
  input wire clkregs_pkg::clk_ctrl_t ctrl_o
);
  import clkregs_pkg::*;
  logic [4:0] scl_hist_r;
  logic       recent_fall;
  // Register writes reach ctrl_o two cycles after a clock fall
  always_ff @(posedge clock_i) scl_hist_r <= {scl_hist_r[3:0], scl_i};
  assign recent_fall = |(scl_hist_r[4:1] & ~scl_hist_r[3:0]);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop_taken;
    stop_phase_tick_i && !software_bus_clock_stop_n_i;
  endsequence
  sequence s_pci_halted;
    ##2 ctrl_o.pci_run == 6'h00;
  endsequence
  a_oe_reset_low: assert property ($rose(nrst_i) |-> !sda_oe_o)
    else $error("sda enable at reset release");
  a_ctrl_reset_zero: assert property ($rose(nrst_i) |-> ctrl_o == '0)
    else $error("ctrl not zero at reset release");
  a_pci_run_cause: assert property ($changed(ctrl_o.pci_run) |->
    $past(stop_phase_tick_i, 2) || recent_fall || !$past(nrst_i, 2) || !$past(nrst_i, 3)
    || $past(power_down_input_i) != $past(power_down_input_i, 2))
    else $error("bus clock run changed without cause");
  a_drive_cause: assert property ($changed({ctrl_o.pci_drive, ctrl_o.free_drive,
    ctrl_o.usb_drive, ctrl_o.ref_drive, ctrl_o.spread_en})
    |-> recent_fall || !$past(nrst_i, 2) || !$past(nrst_i, 3))
    else $error("enable changed without a write");
  a_run_needs_drive: assert property ((ctrl_o.src_run & ~ctrl_o.src_drive) == 6'h00
    && !(ctrl_o.shared_run && !ctrl_o.shared_drive) && !(ctrl_o.dot_run && !ctrl_o.dot_drive))
    else $error("output runs while undriven");
  a_pd_runs_low: assert property ($past(power_down_input_i) |->
    {ctrl_o.shared_run, ctrl_o.src_run, ctrl_o.cpu_run, ctrl_o.pci_run, ctrl_o.free_run,
    ctrl_o.dot_run, ctrl_o.usb_run, ctrl_o.ref_run} == '0)
    else $error("output runs in power down");
  a_stop_halts_pci: assert property (s_stop_taken |-> s_pci_halted)
    else $error("bus clocks not halted by stop");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("sda enable moved with scl high");
  a_start_quiet: assert property (s_start |=> !sda_oe_o [*8])
    else $error("sda driven during address");
endmodule // clock_output_control_regs_checker
bind clock_output_control_regs clock_output_control_regs_checker u_checker (
  .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .power_down_input_i(power_down_input_i), .stop_phase_tick_i(stop_phase_tick_i),
  .software_bus_clock_stop_n_i(software_bus_clock_stop_n_i), .ctrl_o(ctrl_o)
);

// ---- dv/clock_output_control_regs_tb.sv ----
// Purpose: Self-checking bench for the clock output control registers
// Assumes: host_model drives the serial lines, control pins driven here
// Notes:   Read data is checked by a monitor against queued expectations
`timescale 1ns/1ns
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module clock_output_control_regs_tb;
  import clkregs_pkg::*;
  logic       clock_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       pd = 1'b0;
  logic       stop_n = 1'b1;
  logic       sel = 1'b0;
  logic       tick = 1'b0;
  logic       scl, sda, sda_oe, rd_valid;
  logic [7:0] rd_data, exp_rd;
  clk_ctrl_t  ctrl;
  logic [7:0] m [6];
  logic [7:0] q [$];
  int         err_count = 0;
  int         compares = 0;
  int         cycles = 0;
  // Reserved bits held at their fixed values
  logic [7:0] keep [6] = '{8'hFE, 8'hF7, 8'hFF, 8'hFE, 8'h78, 8'h8F};
  logic [7:0] setb [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  clock_output_control_regs u_clock_output_control_regs (
    .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .power_down_input_i(pd), .software_bus_clock_stop_n_i(stop_n),
    .debug_port_clock_select_i(sel), .stop_phase_tick_i(tick), .ctrl_o(ctrl)
  );
  host_model u_host_model (
    .clock_i(clock_i), .dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data)
  );
  function automatic logic [7:0] legal(input int i);
    return (8'($urandom) & keep[i]) | setb[i];
  endfunction
  function automatic clk_ctrl_t exp_ctrl(input logic p, input logic st);
    clk_ctrl_t  c;
    logic       h;
    logic [2:0] f;
    f = {m[2][1:0], m[1][7]};
    h = ~sel & st & m[3][7];
    c.shared_run = m[0][7] & ~p & ~h;
    c.shared_drive = m[0][7] & ~(p & (sel ? m[5][2] : m[5][3])) & ~(h & m[5][7]);
    c.src_run = m[0][6:1] & ~{6{p}} & ~({6{st}} & m[3][6:1]);
    c.src_drive = m[0][6:1] & ~{6{p & m[5][3]}}
      & ~({6{st & m[5][7]}} & m[3][6:1]);
    c.cpu_run = m[1][2:1] & ~{2{p}};
    c.cpu_drive = m[1][2:1] & ~({2{p}} & m[5][1:0]);
    c.pci_drive = m[2][7:2];
    c.pci_run = m[2][7:2] & ~{6{p | st}};
    c.free_drive = f;
    c.free_run = f & ~{3{p}} & ~({3{st}} & m[4][5:3]);
    c.dot_drive = m[1][6] & ~(p & m[4][6]);
    c.dot_run = m[1][6] & ~p;
    c.usb_drive = m[1][5];
    c.usb_run = m[1][5] & ~p;
    c.ref_drive = m[1][4];
    c.ref_run = m[1][4] & ~p;
    c.spread_en = m[1][0];
    return c;
  endfunction
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_host_model.wr_byte(d, a);
    `CHK(a, exp_ack)
  endtask
  task automatic begin_cmd(input logic [7:0] cmd);
    u_host_model.start();
    send(8'hD2, 1'b1);
    send(cmd, 1'b1);
  endtask
  task automatic byte_write(input logic [2:0] ofs, input logic [7:0] d);
    begin_cmd({5'h10, ofs});
    send(d, 1'b1);
    u_host_model.stop();
    if (ofs < 3'd6) m[ofs] = d;
  endtask
  task automatic byte_read(input logic [2:0] ofs);
    begin_cmd({5'h10, ofs});
    u_host_model.start();
    send(8'hD3, 1'b1);
    q.push_back(ofs < 3'd6 ? m[ofs] : 8'h00);
    u_host_model.rd_byte(1'b1);
    u_host_model.stop();
  endtask
  task automatic block_read();
    begin_cmd(8'h00);
    u_host_model.start();
    send(8'hD3, 1'b1);
    q.push_back(BLOCK_READ_COUNT);
    u_host_model.rd_byte(1'b0);
    for (int i = 0; i < 6; i++) begin
      q.push_back(m[i]);
      u_host_model.rd_byte(i == 5);
    end
    u_host_model.stop();
  endtask
  task automatic block_write();
    begin_cmd(8'h00);
    send(8'h06, 1'b1);
    for (int i = 0; i < 6; i++) begin
      m[i] = legal(i);
      send(m[i], 1'b1);
    end
    u_host_model.stop();
  endtask
  task automatic pulse();
    @(posedge clock_i);
    tick <= 1'b1;
    @(posedge clock_i);
    tick <= 1'b0;
  endtask
  task automatic check(input logic p, input logic st);
    @(posedge clock_i);
    pd <= p;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(ctrl, exp_ctrl(p, st))
  endtask
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (rd_valid === 1'b1) begin
      exp_rd = q.pop_front();
      `CHK(rd_data, exp_rd)
    end
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h1EC7FE01));
    m = '{RST_SRC_EN, RST_MISC_EN, RST_BUS_EN, RST_SRC_STOP, RST_FREE_STOP, RST_DRIVE};
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    check(1'b0, 1'b0);
    block_read();
    // Foreign address: nothing acked until the next stop
    u_host_model.start();
    send(8'hD4, 1'b0);
    send(8'h81, 1'b0);
    send(8'h00, 1'b0);
    u_host_model.stop();
    block_write();
    block_read();
    byte_write(3'd6, 8'h5A);
    for (int r = 0; r < 4; r++) begin
      @(posedge clock_i);
      sel <= 1'($urandom);
      for (int i = 0; i < 6; i++) byte_write(3'(i), legal(i));
      for (int i = 0; i < 7; i++) byte_read(3'(i));
      check(1'b1, 1'b0);
      @(posedge clock_i);
      stop_n <= 1'b0;
      check(1'b0, 1'b0);
      pulse();
      check(1'b0, 1'b1);
      check(1'b1, 1'b1);
      @(posedge clock_i);
      stop_n <= 1'b1;
      check(1'b0, 1'b1);
      pulse();
      check(1'b0, 1'b0);
    end
    complete_run();
  end
endmodule // clock_output_control_regs_tb
